// [hdl/cdr_rate_ppm_config.v]
// per-channel cdr rate search, vco frequency check and ctle boost select
// assumes a synchronous register port and inputs synchronous to i_clk
// How it works
// - search divide ratios from divide by 8 down to divide by 1
// - rate and subrate pick the enabled ratios of each group
// - unprogrammed targets default to 1.25 and 10.3125 gbps
// - the check window counts a 25 mhz reference made from the clock
// - count vco/32 pulses over 1024 reference periods
// - group 0 target is 15 bits over two registers, bit 7 manual
// - group 1 target is 15 bits over two registers, bit 7 manual
// - one register holds both 4-bit tolerances, group 0 high nibble
// - ctle override bit applies the override boost register
// - readback register shows the boost actually applied
// - at divide 4 or 8 without override the fixed boost register is applied
// - mute without signal or lock, else retimed unless the mux override bit selects raw

`timescale 1ns/1ps
`include "cdr_rate_ppm_map.vh"

module cdr_rate_ppm_config #(
  parameter REF_DIV = `REF_DIV,
  parameter WINDOW_REFS = `WINDOW_REFS
) (
  input wire i_clk,
  input wire i_rst,
  input wire [7:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  output reg [7:0] o_reg_rdata,
  input wire i_vco_div32_tick,
  input wire i_signal_detect,
  input wire i_lock_lost,
  input wire [7:0] i_adapt_boost,
  output reg [1:0] o_div_code,
  output reg o_vco_group,
  output reg o_measuring,
  output reg o_locked,
  output reg [7:0] o_ctle_boost,
  output wire o_mute,
  output wire o_retimed
);

// ****************************************
// registers
// ****************************************
reg [7:0] boost_ovr_q;
reg [7:0] mux_ctrl_q;
reg [7:0] mux_sel_q;
reg [7:0] ctle_ctrl_q;
reg [7:0] rate_q;
reg [7:0] fixed_boost_q;
reg [7:0] g0_low_q;
reg [7:0] g0_high_q;
reg [7:0] g1_low_q;
reg [7:0] g1_high_q;
reg [7:0] tol_q;

always @(posedge i_clk) begin
  if (i_rst) begin
    boost_ovr_q <= `RST_BYTE;
    mux_ctrl_q <= `RST_BYTE;
    mux_sel_q <= `RST_BYTE;
    ctle_ctrl_q <= `RST_BYTE;
    rate_q <= `RST_BYTE;
    fixed_boost_q <= `RST_BYTE;
    g0_low_q <= `RST_BYTE;
    g0_high_q <= `RST_BYTE;
    g1_low_q <= `RST_BYTE;
    g1_high_q <= `RST_BYTE;
    tol_q <= `RST_TOL;
  end else if (i_reg_wr) begin
    case (i_reg_addr)
      `OFS_BOOST_OVR: boost_ovr_q <= i_reg_wdata;
      `OFS_MUX_CTRL: mux_ctrl_q <= i_reg_wdata;
      `OFS_MUX_SEL: mux_sel_q <= i_reg_wdata;
      `OFS_CTLE_CTRL: ctle_ctrl_q <= i_reg_wdata;
      `OFS_RATE: rate_q <= i_reg_wdata;
      `OFS_FIXED_BOOST: fixed_boost_q <= i_reg_wdata;
      `OFS_G0_LOW: g0_low_q <= i_reg_wdata;
      `OFS_G0_HIGH: g0_high_q <= i_reg_wdata;
      `OFS_G1_LOW: g1_low_q <= i_reg_wdata;
      `OFS_G1_HIGH: g1_high_q <= i_reg_wdata;
      `OFS_TOL: tol_q <= i_reg_wdata;
      default: ;
    endcase
  end
end

// ****************************************
// register read
// ****************************************
reg [7:0] rd_d;
always @* begin
  case (i_reg_addr)
    `OFS_BOOST_OVR: rd_d = boost_ovr_q;
    `OFS_MUX_CTRL: rd_d = mux_ctrl_q;
    `OFS_MUX_SEL: rd_d = mux_sel_q;
    `OFS_CTLE_CTRL: rd_d = ctle_ctrl_q;
    `OFS_RATE: rd_d = rate_q;
    `OFS_FIXED_BOOST: rd_d = fixed_boost_q;
    `OFS_BOOST_RB: rd_d = o_ctle_boost;
    `OFS_G0_LOW: rd_d = g0_low_q;
    `OFS_G0_HIGH: rd_d = g0_high_q;
    `OFS_G1_LOW: rd_d = g1_low_q;
    `OFS_G1_HIGH: rd_d = g1_high_q;
    `OFS_TOL: rd_d = tol_q;
    default: rd_d = `RD_UNMAPPED;
  endcase
end

always @(posedge i_clk) begin
  if (i_rst) begin
    o_reg_rdata <= `RST_BYTE;
  end else if (i_reg_rd) begin
    o_reg_rdata <= rd_d;
  end
end

// ****************************************
// targets and tolerances
// ****************************************
wire [14:0] g0_target;
wire [14:0] g1_target;
wire [3:0] g0_tol;
wire [3:0] g1_tol;

assign g0_target = g0_high_q[`MANUAL_BIT] ?
  {g0_high_q[6:0], g0_low_q} : `G0_DEFAULT_COUNT;
assign g1_target = g1_high_q[`MANUAL_BIT] ?
  {g1_high_q[6:0], g1_low_q} : `G1_DEFAULT_COUNT;
assign g0_tol = tol_q[`TOL0_MSB:`TOL0_LSB];
assign g1_tol = tol_q[`TOL1_MSB:`TOL1_LSB];

// ****************************************
// enabled ratio lookup
// ****************************************
wire [3:0] rate_idx;
wire [63:0] g0_masks;
wire [63:0] g1_masks;
wire [3:0] g0_en;
wire [3:0] g1_en;

assign rate_idx = rate_q[`RATE_MSB:`RATE_LSB];
assign g0_masks = `G0_RATIO_MASKS;
assign g1_masks = `G1_RATIO_MASKS;
assign g0_en = g0_masks[{rate_idx, 2'h0} +: 4];
assign g1_en = g1_masks[{rate_idx, 2'h0} +: 4];

// ****************************************
// reference tick divider
// ****************************************
localparam REF_W = 8;
reg [REF_W-1:0] ref_cnt_q;
wire ref_tick;
assign ref_tick = (ref_cnt_q == REF_DIV[REF_W-1:0] - 1'b1);

always @(posedge i_clk) begin
  if (i_rst || ref_tick) begin
    ref_cnt_q <= {REF_W{1'b0}};
  end else begin
    ref_cnt_q <= ref_cnt_q + 1'b1;
  end
end

// ****************************************
// search state machine
// ****************************************
localparam ST_IDLE = 4'b0001;
localparam ST_SEEK = 4'b0010;
localparam ST_MEAS = 4'b0100;
localparam ST_LOCK = 4'b1000;
localparam WIN_W = 12;

reg [3:0] state_q;
reg [2:0] cursor_q;
reg [WIN_W-1:0] win_q;
reg [15:0] vco_cnt_q;

wire [1:0] cur_div;
wire cur_grp;
wire cur_en;
wire win_done;
wire [15:0] tgt;
wire [15:0] tol;
wire [15:0] diff;
wire match;
wire [15:0] cnt_now;

assign cur_div = cursor_q[2:1];
assign cur_grp = ~cursor_q[0];
assign cur_en = cur_grp ? g1_en[cur_div] : g0_en[cur_div];
assign win_done = ref_tick &&
  (win_q == WINDOW_REFS[WIN_W-1:0] - 1'b1);
assign tgt = {1'b0, o_vco_group ? g1_target : g0_target};
assign tol = {12'h000, o_vco_group ? g1_tol : g0_tol};
assign cnt_now = (i_vco_div32_tick && vco_cnt_q != 16'hffff) ?
  vco_cnt_q + 16'h0001 : vco_cnt_q;
assign diff = (cnt_now >= tgt) ? cnt_now - tgt : tgt - cnt_now;
assign match = (diff <= tol);

always @(posedge i_clk) begin
  if (i_rst) begin
    state_q <= ST_IDLE;
    cursor_q <= `CURSOR_START;
    win_q <= {WIN_W{1'b0}};
    vco_cnt_q <= 16'h0000;
    o_div_code <= `DIV_CODE_8;
    o_vco_group <= 1'b0;
    o_measuring <= 1'b0;
    o_locked <= 1'b0;
  end else if (!i_signal_detect) begin
    state_q <= ST_IDLE;
    cursor_q <= `CURSOR_START;
    o_measuring <= 1'b0;
    o_locked <= 1'b0;
  end else begin
    case (state_q)
      ST_IDLE: begin
        cursor_q <= `CURSOR_START;
        state_q <= ST_SEEK;
      end
      ST_SEEK: begin
        if (!cur_en) begin
          cursor_q <= cursor_q - 1'b1;
        end else if (ref_tick) begin
          // window opens on a reference tick
          o_div_code <= cur_div;
          o_vco_group <= cur_grp;
          o_measuring <= 1'b1;
          win_q <= {WIN_W{1'b0}};
          vco_cnt_q <= 16'h0000;
          state_q <= ST_MEAS;
        end
      end
      ST_MEAS: begin
        vco_cnt_q <= cnt_now;
        if (ref_tick) begin
          win_q <= win_q + 1'b1;
        end
        if (win_done) begin
          o_measuring <= 1'b0;
          if (match) begin
            o_locked <= 1'b1;
            state_q <= ST_LOCK;
          end else begin
            cursor_q <= cursor_q - 1'b1;
            state_q <= ST_SEEK;
          end
        end
      end
      ST_LOCK: begin
        if (i_lock_lost) begin
          o_locked <= 1'b0;
          state_q <= ST_IDLE;
        end
      end
      default: begin
        state_q <= ST_IDLE;
      end
    endcase
  end
end

// ****************************************
// ctle boost select
// ****************************************
wire low_div;
reg [7:0] boost_d;
assign low_div = (o_div_code == `DIV_CODE_4) ||
  (o_div_code == `DIV_CODE_8);

always @* begin
  if (ctle_ctrl_q[`CTLE_OVR_BIT]) begin
    boost_d = boost_ovr_q;
  end else if (low_div) begin
    boost_d = fixed_boost_q;
  end else begin
    boost_d = i_adapt_boost;
  end
end

always @(posedge i_clk) begin
  if (i_rst) begin
    o_ctle_boost <= `RST_BYTE;
  end else begin
    o_ctle_boost <= boost_d;
  end
end

// ****************************************
// output status
// ****************************************
assign o_mute = !(i_signal_detect && o_locked);
assign o_retimed = mux_ctrl_q[`MUX_OVR_BIT] ?
  mux_sel_q[`RETIME_BIT] : 1'b1;

endmodule // cdr_rate_ppm_config

// [hdl/cdr_rate_ppm_map.vh]
// constants of the cdr rate search and frequency check block
// assumes inclusion by bare name from the design file
`ifndef CDR_RATE_PPM_MAP_VH
`define CDR_RATE_PPM_MAP_VH
// ****************************************
// register offsets
// ****************************************
`define OFS_BOOST_OVR 8'h03
`define OFS_MUX_CTRL 8'h09
`define OFS_MUX_SEL 8'h1e
`define OFS_CTLE_CTRL 8'h2d
`define OFS_RATE 8'h2f
`define OFS_FIXED_BOOST 8'h3a
`define OFS_BOOST_RB 8'h52
`define OFS_G0_LOW 8'h60
`define OFS_G0_HIGH 8'h61
`define OFS_G1_LOW 8'h62
`define OFS_G1_HIGH 8'h63
`define OFS_TOL 8'h64
// ****************************************
// reset values
// ****************************************
`define RST_BYTE 8'h00
`define RST_TOL 8'hcd
`define RD_UNMAPPED 8'h00
// ****************************************
// field positions
// ****************************************
`define MANUAL_BIT 7
`define CTLE_OVR_BIT 3
`define MUX_OVR_BIT 5
`define RETIME_BIT 7
`define RATE_MSB 7
`define RATE_LSB 4
`define TOL0_MSB 7
`define TOL0_LSB 4
`define TOL1_MSB 3
`define TOL1_LSB 0
// ****************************************
// divide ratio codes: 0 div1, 1 div2, 2 div4, 3 div8
// ****************************************
`define DIV_CODE_1 2'h0
`define DIV_CODE_4 2'h2
`define DIV_CODE_8 2'h3
`define CURSOR_START 3'h7
// enabled ratio masks, 4 bits per rate/subrate, bit n is ratio code n
`define G0_RATIO_MASKS 64'h8111_6211_1f56_7778
`define G1_RATIO_MASKS 64'h1111_6211_1f56_7711
// default targets: 1.25 gbps x8 and 10.3125 gbps x1 as vco/32 counts
`define G0_DEFAULT_COUNT 15'h3200
`define G1_DEFAULT_COUNT 15'h3390
// ****************************************
// timing
// ****************************************
`define CLK_MHZ 100
`define REF_MHZ 25
`define REF_DIV (`CLK_MHZ / `REF_MHZ)
`define WINDOW_REFS 1024
`endif

// [tb/vco_tick_src.sv]
// vco divided by 32 seen as a pulse every i_per clocks
// assumes i_per of 1 or more, ticks only while enabled
`timescale 1ns/1ps
module vco_tick_src (
  input wire i_clk,
  input wire i_en,
  input wire [3:0] i_per,
  output reg o_tick
);
  reg [3:0] cnt_q = 4'h0;
  initial o_tick = 1'b0;
  always @(posedge i_clk) begin
    cnt_q <= (cnt_q + 4'h1 >= i_per) ? 4'h0 : cnt_q + 4'h1;
    o_tick <= i_en && (cnt_q == 4'h0);
  end
endmodule // vco_tick_src

// [tb/cdr_rate_ppm_config_assertions.sv]
// port checker for the cdr rate search block
// assumes bind onto the design top, one clock
`timescale 1ns/1ps
module cdr_rate_ppm_chk #(
  parameter REF_DIV = 4,
  parameter WINDOW_REFS = 1024
) (
  input wire i_clk,
  input wire i_rst,
  input wire [7:0] i_reg_addr,
  input wire i_reg_rd,
  input wire [7:0] o_reg_rdata,
  input wire i_signal_detect,
  input wire i_lock_lost,
  input wire [1:0] o_div_code,
  input wire o_vco_group,
  input wire o_measuring,
  input wire o_locked,
  input wire [7:0] o_ctle_boost,
  input wire o_mute
);
  localparam integer LEN = WINDOW_REFS * REF_DIV;
  reg [15:0] win_q;
  reg [1:0] top_q;
  reg top_ok_q;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ****************************************
  // helper: length of the current window
  // ****************************************
  always @(posedge i_clk) begin
    if (i_rst)
      win_q <= 16'h0;
    else
      win_q <= o_measuring ? win_q + 16'h1 : 16'h0;
  end
  // helper: first ratio tried since reset or the last loss of signal detect
  always @(posedge i_clk) begin
    if (i_rst || !i_signal_detect) begin
      top_ok_q <= 1'b0;
      top_q <= 2'h0;
    end else if ($rose(o_measuring) && !top_ok_q) begin
      top_ok_q <= 1'b1;
      top_q <= o_div_code;
    end
  end
  sequence win_done;
    $fell(o_measuring) && $past(i_signal_detect) && !$past(i_lock_lost);
  endsequence
  sequence boost_read;
    i_reg_rd && i_reg_addr == 8'h52;
  endsequence
  window_len_a: assert property (win_done |-> win_q == LEN)
    else $error("window length differs from the set span");
  boost_rb_a: assert property (boost_read
    |=> o_reg_rdata == $past(o_ctle_boost))
    else $error("readback differs from applied boost");
  mute_state_a: assert property (o_mute
    == !(i_signal_detect && o_locked))
    else $error("mute not set by signal and lock");
  nosig_idle_a: assert property (!i_signal_detect
    |=> !o_measuring && !o_locked)
    else $error("search kept running without signal");
  lock_hold_a: assert property (o_locked && i_signal_detect
    && !i_lock_lost |=> o_locked)
    else $error("lock dropped without cause");
  lock_cause_a: assert property ($rose(o_locked)
    |-> $past(o_measuring) || $past(o_measuring, 2))
    else $error("lock without a measurement");
  ratio_order_a: assert property ($changed(o_div_code)
    |-> o_div_code < $past(o_div_code) || !top_ok_q || o_div_code == top_q)
    else $error("divide ratio out of search order");
  meas_stable_a: assert property (o_measuring && $past(o_measuring)
    |-> $stable(o_div_code) && $stable(o_vco_group))
    else $error("candidate changed inside a window");
endmodule // cdr_rate_ppm_chk
bind cdr_rate_ppm_config cdr_rate_ppm_chk #(.REF_DIV(REF_DIV),
  .WINDOW_REFS(WINDOW_REFS)) u_chk (.i_clk(i_clk), .i_rst(i_rst),
  .i_reg_addr(i_reg_addr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
  .i_signal_detect(i_signal_detect), .i_lock_lost(i_lock_lost),
  .o_div_code(o_div_code), .o_vco_group(o_vco_group),
  .o_measuring(o_measuring), .o_locked(o_locked),
  .o_ctle_boost(o_ctle_boost), .o_mute(o_mute));

// [tb/test_cdr_rate_ppm_config.sv]
// self-checking bench for the cdr rate search block
// assumes the design, the vco model and the bound checker
`timescale 1ns/1ps
module test_cdr_rate_ppm_config;
  localparam W = 8;
  localparam R = 4;
  reg i_clk = 1'b0;
  reg i_rst = 1'b1;
  reg [7:0] i_reg_addr = 8'h00;
  reg [7:0] i_reg_wdata = 8'h00;
  reg i_reg_wr = 1'b0;
  reg i_reg_rd = 1'b0;
  reg i_signal_detect = 1'b0;
  reg i_lock_lost = 1'b0;
  reg [7:0] i_adapt_boost = 8'h00;
  reg vco_en = 1'b0;
  reg [3:0] per = 4'h2;
  reg [7:0] v, q, a;
  wire tick, o_mute, o_retimed, o_vco_group, o_measuring, o_locked;
  wire [7:0] o_reg_rdata, o_ctle_boost;
  wire [1:0] o_div_code;
  integer err_total = 0;
  integer checks = 0;
  always #5 i_clk = ~i_clk;
  cdr_rate_ppm_config #(.REF_DIV(R), .WINDOW_REFS(W)) uut (.i_clk(i_clk),
    .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .i_vco_div32_tick(tick), .i_signal_detect(i_signal_detect),
    .i_lock_lost(i_lock_lost), .i_adapt_boost(i_adapt_boost),
    .o_div_code(o_div_code), .o_vco_group(o_vco_group),
    .o_measuring(o_measuring), .o_locked(o_locked),
    .o_ctle_boost(o_ctle_boost), .o_mute(o_mute), .o_retimed(o_retimed));
  vco_tick_src u_vco (.i_clk(i_clk), .i_en(vco_en), .i_per(per),
    .o_tick(tick));
  // ****************************************
  // helpers
  // ****************************************
  function [7:0] cnt(input [3:0] p);
    cnt = 8'(W * R / p);
  endfunction
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge i_clk);
      #1;
    end
  endtask
  task wr(input [7:0] ad, input [7:0] d);
    begin
      cyc(1);
      i_reg_addr = ad;
      i_reg_wdata = d;
      i_reg_wr = 1'b1;
      cyc(1);
      i_reg_wr = 1'b0;
    end
  endtask
  task rd(input [7:0] ad, output [7:0] d);
    begin
      cyc(1);
      i_reg_addr = ad;
      i_reg_rd = 1'b1;
      cyc(1);
      i_reg_rd = 1'b0;
      d = o_reg_rdata;
    end
  endtask
  task wait_lock;
    integer n;
    begin
      for (n = 0; n < 3000 && o_locked !== 1'b1; n = n + 1)
        cyc(1);
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    #200000;
    err_total = err_total + 1;
    end_of_test;
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    v = $urandom(32'h2f1c0bf6);
    i_adapt_boost = $urandom;
    cyc(16);
    i_rst = 1'b0;
    rd(8'h64, q); chk(q, 8'hcd);
    rd(8'h52, q); chk(q, 8'h00);
    wr(8'h52, 8'hff); rd(8'h52, q); chk(q, 8'h00);
    wr(8'h40, 8'hff); rd(8'h40, q); chk(q, 8'h00);
    for (a = 8'h60; a < 8'h65; a = a + 8'h1) begin
      v = $urandom;
      wr(a, v); rd(a, q); chk(q, v);
    end
    $display("test 1 done");
    wr(8'h61, 8'h00); wr(8'h63, 8'h00);
    vco_en = 1'b1;
    i_signal_detect = 1'b1;
    cyc(150); chk(8'(o_locked), 8'h0);
    wr(8'h64, 8'h10); wr(8'h60, cnt(per)); wr(8'h61, 8'h80);
    wait_lock; chk(8'(o_locked), 8'h1);
    chk(8'(o_div_code), 8'h3); chk(8'(o_vco_group), 8'h0);
    v = $urandom;
    wr(8'h3a, v); cyc(1); chk(o_ctle_boost, v);
    rd(8'h52, q); chk(q, v);
    v = $urandom;
    wr(8'h03, v); wr(8'h2d, 8'h08); cyc(1); chk(o_ctle_boost, v);
    wr(8'h2d, 8'h00); wr(8'h3a, 8'h00);
    cyc(1); chk(o_ctle_boost, 8'h00);
    chk(8'(o_retimed), 8'h1); chk(8'(o_mute), 8'h0);
    wr(8'h09, 8'h20); wr(8'h1e, 8'h00); chk(8'(o_retimed), 8'h0);
    wr(8'h1e, 8'h80); chk(8'(o_retimed), 8'h1);
    i_signal_detect = 1'b0;
    #1 chk(8'(o_mute), 8'h1);
    cyc(1); chk(8'(o_locked), 8'h0);
    $display("test 2 done");
    wr(8'h64, 8'h00); wr(8'h60, cnt(per) + 8'h1);
    i_signal_detect = 1'b1;
    cyc(200); chk(8'(o_locked), 8'h0);
    wr(8'h64, 8'h10);
    wait_lock; chk(8'(o_locked), 8'h1);
    i_signal_detect = 1'b0;
    $display("test 3 done");
    per = 4'h1 << ($urandom % 3);
    wr(8'h2f, 8'h70); wr(8'h61, 8'h00); wr(8'h64, 8'h01);
    wr(8'h62, cnt(per)); wr(8'h63, 8'h80);
    i_signal_detect = 1'b1;
    wait_lock; chk(8'(o_div_code), 8'h0);
    chk(8'(o_vco_group), 8'h1);
    cyc(1); chk(o_ctle_boost, i_adapt_boost);
    i_lock_lost = 1'b1;
    cyc(1);
    i_lock_lost = 1'b0;
    chk(8'(o_locked), 8'h0);
    wait_lock; chk(8'(o_locked), 8'h1);
    $display("test 4 done");
    end_of_test;
  end
endmodule // test_cdr_rate_ppm_config
